/* File: tb.sv */
`timescale 1ns/1ps

module tb;
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
        logic err;
    } tpw_row_t;

    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, pin, pin_en, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] per, hi, rises;
    int err_total, samples_checked, cnt, div;
    tpw_row_t rows [16];
    logic [7:0] c_pr [5];
    logic [9:0] c_du [5];
    logic [1:0] c_ps [5];

    tpw_unit uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modulator_output_pin(pin), .modulator_output_enable(pin_en));
    tpw_pin_load load (.clk(clk), .rst_b(rst_b), .pin(pin), .pin_enable(pin_en),
        .period_clks(per), .high_clks(hi), .rises(rises));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask : check

    // one transfer, then an idle cycle so strobes never toggle twice at one edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 10);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
        @(posedge clk);
    endtask : apb

    task automatic wait_rises(input int k);
        int r0, n;
        r0 = rises;
        n = 0;
        while (rises < r0 + k && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            err_total++;
            close_out();
        end
    endtask : wait_rises

    task automatic count_level(input logic lvl);
        cnt = 0;
        repeat (300) begin
            @(posedge clk);
            if (pin === lvl) cnt++;
        end
    endtask : count_level

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        rows = '{'{1'b0, 12'h02C, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h030, 8'h00, 8'h00, 1'b0},
            '{1'b0, 12'h044, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h048, 8'h00, 8'h00, 1'b0},
            '{1'b0, 12'h054, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h058, 8'h00, 8'h00, 1'b0},
            '{1'b0, 12'h05C, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h218, 8'h00, 8'hFF, 1'b0},
            '{1'b0, 12'h230, 8'h00, 8'h00, 1'b0}, '{1'b0, 12'h248, 8'h00, 8'hFF, 1'b0},
            '{1'b1, 12'h230, 8'hFF, 8'hF7, 1'b0}, '{1'b1, 12'h05C, 8'hFF, 8'h3F, 1'b0},
            '{1'b1, 12'h05C, 8'h00, 8'h00, 1'b0}, '{1'b1, 12'h02C, 8'hA5, 8'hA5, 1'b0},
            '{1'b1, 12'h100, 8'h12, 8'h00, 1'b1}, '{1'b0, 12'h045, 8'h00, 8'h00, 1'b1}};
        c_pr = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h01};
        c_du = '{10'h002, 10'h002, 10'h002, 10'h00D, 10'h002};
        c_ps = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({31'h0, pin}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].addr, rows[i].wd);
            apb(1'b0, rows[i].addr, 8'h00);
            check(rd, {24'h000000, rows[i].exp});
            check({31'h0, er}, {31'h0, rows[i].err});
        end
        // one configuration per prescale code, plus a full 10-bit duty
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h048, 8'h00);
            apb(1'b1, 12'h044, 8'h00);
            apb(1'b1, 12'h05C, 8'h00);
            apb(1'b1, 12'h248, c_pr[i]);
            apb(1'b1, 12'h054, c_du[i][9:2]);
            apb(1'b1, 12'h05C, {2'b00, c_du[i][1:0], 4'hC});
            apb(1'b1, 12'h218, 8'hF7);
            apb(1'b1, 12'h048, {5'h00, 1'b1, c_ps[i]});
            div = (c_ps[i] == 2'h0) ? 1 : ((c_ps[i] == 2'h1) ? 4 : 16);
            wait_rises(3);
            check({16'h0, per}, (32'(c_pr[i]) + 1) * 4 * div);
            check({16'h0, hi}, 32'(c_du[i]) * div);
        end
        check({31'h0, pin_en}, 32'h1);
        // ---------------------------------------------------------------
        // awkward cases on the running period of 128 clocks
        // ---------------------------------------------------------------
        wait_rises(1);
        apb(1'b1, 12'h054, 8'h10);
        apb(1'b0, 12'h058, 8'h00);
        check(rd, 32'h00000000);
        wait_rises(1);
        apb(1'b0, 12'h058, 8'h00);
        check(rd, 32'h00000010);
        apb(1'b1, 12'h058, 8'hAA);
        apb(1'b0, 12'h058, 8'h00);
        check(rd, 32'h00000010);
        count_level(1'b0);
        check(32'(cnt), 32'h0);
        apb(1'b1, 12'h05C, 8'h00);
        repeat (3) @(posedge clk);
        check({31'h0, pin}, 32'h0);
        apb(1'b1, 12'h054, 8'h00);
        apb(1'b1, 12'h05C, 8'h0C);
        count_level(1'b1);
        check(32'(cnt), 32'h0);
        apb(1'b1, 12'h054, 8'h40);
        apb(1'b1, 12'h05C, 8'h38);
        count_level(1'b1);
        check(32'(cnt), 32'h0);
        close_out();
    end
endmodule : tb

/* File: tpw_pin_load.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// pin load: measures last full period and last high time in clocks
// ---------------------------------------------------------------
module tpw_pin_load (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    input wire logic pin_enable,
    output logic [15:0] period_clks,
    output logic [15:0] high_clks,
    output logic [15:0] rises
);
    logic seen;
    logic prev;
    logic [15:0] since;
    logic [15:0] hcnt;

    // undriven pin reads low, as through a pull-down
    assign seen = pin_enable & pin;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
            since <= 16'h0000;
            hcnt <= 16'h0000;
            period_clks <= 16'h0000;
            high_clks <= 16'h0000;
            rises <= 16'h0000;
        end else begin
            prev <= seen;
            since <= since + 16'h0001;
            hcnt <= hcnt + 16'h0001;
            if (seen && !prev) begin
                period_clks <= since;
                since <= 16'h0001;
                hcnt <= 16'h0001;
                rises <= rises + 16'h0001;
            end
            if (!seen && prev) begin
                high_clks <= hcnt;
            end
        end
    end
endmodule : tpw_pin_load

/* File: tpw_pkg.sv */
package tpw_pkg;

    // ---------------------------------------------------------------
    // register indices, byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_TIMER_COUNT = 8'h11;
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
    localparam logic [7:0] IDX_DUTY_UPPER_BYTE = 8'h15;
    localparam logic [7:0] IDX_DUTY_SHADOW_BYTE = 8'h16;
    localparam logic [7:0] IDX_MODULE_CONTROL = 8'h17;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
    localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD_COMPARE = 8'h92;

    // ---------------------------------------------------------------
    // reset values and readable masks
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PERIOD_COMPARE = 8'hFF;
    localparam logic [7:0] MASK_IRQ_REGS = 8'hF7;
    localparam logic [7:0] MASK_TIMER_CONTROL = 8'h7F;
    localparam logic [7:0] MASK_MODULE_CONTROL = 8'h3F;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int TC_PRESCALE_LSB = 0;
    localparam int TC_RUN_BIT = 2;
    localparam int TC_POSTSCALE_LSB = 3;
    localparam int MC_MODE_LSB = 0;
    localparam int MC_DUTY_LOW_LSB = 4;
    localparam int FLAG_TIMER_MATCH = 1;
    localparam int DIR_MODULATOR_PIN = 3;

    // ---------------------------------------------------------------
    // timing counts: phases per timer tick, and clocks per phase for each prescale ratio
    // ---------------------------------------------------------------
    localparam int PHASES_PER_TICK = 4;
    localparam int PRESCALE_DIV1 = 1;
    localparam int PRESCALE_DIV4 = 4;
    localparam int PRESCALE_DIV16 = 16;

    typedef enum logic [1:0] {MODE_OFF, MODE_OTHER, MODE_PWM} tpw_mode_t;

    typedef enum logic [3:0] {
        REG_NONE, REG_INTERRUPT_CONTROL, REG_PIRF, REG_TCOUNT, REG_TCTRL, REG_DUTY_HI,
        REG_SHADOW, REG_MCTRL, REG_DIR, REG_PIEN, REG_PERIOD
    } tpw_reg_t;

endpackage : tpw_pkg

/* File: tpw_prescaler.sv */
`timescale 1ns/1ps

module tpw_prescaler (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic clr,
    input wire logic [1:0] prescale_select,
    output logic [1:0] phase,
    output logic tick
);

    typedef struct packed {
        logic [3:0] sub;
        logic [1:0] phase;
    } tpw_pre_state_t;

    tpw_pre_state_t st;
    tpw_pre_state_t next_st;
    logic [3:0] limit;

    // ---------------------------------------------------------------
    // ratio decode
    // ---------------------------------------------------------------
    function automatic logic [3:0] tpw_limit(input logic [1:0] sel);
        case (sel)
            2'b00: tpw_limit = 4'(tpw_pkg::PRESCALE_DIV1 - 1);
            2'b01: tpw_limit = 4'(tpw_pkg::PRESCALE_DIV4 - 1);
            default: tpw_limit = 4'(tpw_pkg::PRESCALE_DIV16 - 1);
        endcase
    endfunction : tpw_limit

    always_comb begin
        limit = tpw_limit(prescale_select);
        next_st = st;
        if (clr) begin
            next_st = '0;
        end else if (run) begin
            if (st.sub >= limit) begin
                next_st.sub = 4'h0;
                next_st.phase = st.phase + 2'h1;
            end else begin
                next_st.sub = st.sub + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // one timer increment every four phases of prescale clocks each
    // phase after this edge, so the duty compare lands as the count arrives
    assign phase = next_st.phase;
    assign tick = run && !clr && st.phase == 2'(tpw_pkg::PHASES_PER_TICK - 1) && st.sub >= limit;

endmodule : tpw_prescaler

/* File: tpw_unit.sv */
`timescale 1ns/1ps

// Summary of operation
// - period lasts (period value + 1) x 4 clocks x prescale ratio.
// - count equal to period value clears count at next increment.
// - rollover drives pin high, except duty zero keeps it low.
// - rollover copies duty byte and two low bits into shadow and latch.
// - duty is 10 bits: duty byte high, module control bits 5:4 low.
// - high time equals duty x clock x prescale ratio.
// - duty writes take effect only at the next period match.
// - shadow duty byte ignores writes in modulator mode.
// - pin clears when buffered duty equals count extended by phase bits.
// - duty beyond period never clears pin, output stays high.
// - prescaler divides by 1, 4 or 16.
// - writing zero to module control forces output latch low.
module tpw_unit #(
    parameter int PADDR_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic modulator_output_pin,
    output logic modulator_output_enable
);

    if (PADDR_W < 10) begin : g_addr_chk
        $error("tpw_unit: PADDR_W must be at least 10");
    end

    typedef struct packed {
        logic [7:0] interrupt_control;
        logic [7:0] peripheral_irq_flags;
        logic [7:0] timer_count;
        logic [7:0] timer_control;
        logic [7:0] duty_upper_byte;
        logic [7:0] duty_shadow_byte;
        logic [7:0] module_control;
        logic [7:0] port_b_direction;
        logic [7:0] peripheral_irq_enables;
        logic [7:0] period_compare;
        logic [1:0] duty_low_latch;
        logic out_latch;
        logic [3:0] post;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic pin;
        logic pin_oe;
    } tpw_state_t;

    tpw_state_t st;
    tpw_state_t next_st;
    logic [1:0] phase;
    logic tick;
    logic run;
    logic pwm;
    logic rollover;
    logic duty_match;
    logic wr;
    logic clr_pre;
    tpw_pkg::tpw_reg_t rid;
    logic [9:0] duty_buf;
    logic [9:0] duty_prog;
    logic [7:0] count_next;

    // ---------------------------------------------------------------
    // decoding
    // ---------------------------------------------------------------
    function automatic tpw_pkg::tpw_reg_t tpw_decode(input logic [PADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        tpw_decode = tpw_pkg::REG_NONE;
        if ((a >> 10) == '0 && a[1:0] == 2'b00) begin
            case (idx)
                tpw_pkg::IDX_INTERRUPT_CONTROL: tpw_decode = tpw_pkg::REG_INTERRUPT_CONTROL;
                tpw_pkg::IDX_PERIPHERAL_IRQ_FLAGS: tpw_decode = tpw_pkg::REG_PIRF;
                tpw_pkg::IDX_TIMER_COUNT: tpw_decode = tpw_pkg::REG_TCOUNT;
                tpw_pkg::IDX_TIMER_CONTROL: tpw_decode = tpw_pkg::REG_TCTRL;
                tpw_pkg::IDX_DUTY_UPPER_BYTE: tpw_decode = tpw_pkg::REG_DUTY_HI;
                tpw_pkg::IDX_DUTY_SHADOW_BYTE: tpw_decode = tpw_pkg::REG_SHADOW;
                tpw_pkg::IDX_MODULE_CONTROL: tpw_decode = tpw_pkg::REG_MCTRL;
                tpw_pkg::IDX_PORT_B_DIRECTION: tpw_decode = tpw_pkg::REG_DIR;
                tpw_pkg::IDX_PERIPHERAL_IRQ_ENABLES: tpw_decode = tpw_pkg::REG_PIEN;
                tpw_pkg::IDX_PERIOD_COMPARE: tpw_decode = tpw_pkg::REG_PERIOD;
                default: tpw_decode = tpw_pkg::REG_NONE;
            endcase
        end
    endfunction : tpw_decode

    function automatic tpw_pkg::tpw_mode_t tpw_mode(input logic [7:0] mc);
        logic [3:0] f;
        f = mc[tpw_pkg::MC_MODE_LSB +: 4];
        if (f[3:2] == 2'b11) begin
            tpw_mode = tpw_pkg::MODE_PWM;
        end else if (f == 4'h0) begin
            tpw_mode = tpw_pkg::MODE_OFF;
        end else begin
            tpw_mode = tpw_pkg::MODE_OTHER;
        end
    endfunction : tpw_mode

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    tpw_prescaler u_prescaler (
        .clk(clk),
        .rst_b(rst_b),
        .run(run),
        .clr(clr_pre),
        .prescale_select(st.timer_control[tpw_pkg::TC_PRESCALE_LSB +: 2]),
        .phase(phase),
        .tick(tick)
    );

    always_comb begin
        run = st.timer_control[tpw_pkg::TC_RUN_BIT];
        pwm = tpw_mode(st.module_control) == tpw_pkg::MODE_PWM;
        rid = tpw_decode(paddr);
        wr = psel && penable && st.pready && pwrite;
        clr_pre = wr && (rid == tpw_pkg::REG_TCOUNT || rid == tpw_pkg::REG_TCTRL);
        rollover = tick && st.timer_count == st.period_compare;
        duty_buf = {st.duty_shadow_byte, st.duty_low_latch};
        duty_prog = {st.duty_upper_byte, st.module_control[tpw_pkg::MC_DUTY_LOW_LSB +: 2]};
        // compare the value after this edge, else the high time runs one clock long
        count_next = rollover ? 8'h00 : (tick ? st.timer_count + 8'h01 : st.timer_count);
        // a duty above the last count never matches, so the pin stays high
        duty_match = duty_buf == {count_next, phase};
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [7:0] rd;
        logic flag_set;
        rd = 8'h00;
        flag_set = 1'b0;
        next_st = st;

        // timer and period
        if (tick) begin
            if (rollover) begin
                next_st.timer_count = 8'h00;
                if (st.post == st.timer_control[tpw_pkg::TC_POSTSCALE_LSB +: 4]) begin
                    next_st.post = 4'h0;
                    flag_set = 1'b1;
                end else begin
                    next_st.post = st.post + 4'h1;
                end
                if (pwm) begin
                    next_st.duty_shadow_byte = st.duty_upper_byte;
                    next_st.duty_low_latch = st.module_control[tpw_pkg::MC_DUTY_LOW_LSB +: 2];
                    next_st.out_latch = duty_prog != 10'h000;
                end
            end else begin
                next_st.timer_count = st.timer_count + 8'h01;
            end
        end
        // end of high time, count and duty both in prescaled clock units
        if (pwm && !rollover && duty_match) begin
            next_st.out_latch = 1'b0;
        end

        // apb read, answered in the access cycle
        next_st.pready = psel && !penable;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (rid)
                tpw_pkg::REG_INTERRUPT_CONTROL: rd = st.interrupt_control;
                tpw_pkg::REG_PIRF: rd = st.peripheral_irq_flags & tpw_pkg::MASK_IRQ_REGS;
                tpw_pkg::REG_TCOUNT: rd = st.timer_count;
                tpw_pkg::REG_TCTRL: rd = st.timer_control & tpw_pkg::MASK_TIMER_CONTROL;
                tpw_pkg::REG_DUTY_HI: rd = st.duty_upper_byte;
                tpw_pkg::REG_SHADOW: rd = st.duty_shadow_byte;
                tpw_pkg::REG_MCTRL: rd = st.module_control & tpw_pkg::MASK_MODULE_CONTROL;
                tpw_pkg::REG_DIR: rd = st.port_b_direction;
                tpw_pkg::REG_PIEN: rd = st.peripheral_irq_enables & tpw_pkg::MASK_IRQ_REGS;
                tpw_pkg::REG_PERIOD: rd = st.period_compare;
                default: rd = 8'h00;
            endcase
            next_st.prdata = {24'h00_0000, rd};
            next_st.pslverr = rid == tpw_pkg::REG_NONE;
        end

        // apb write, takes effect at the access edge
        if (wr) begin
            case (rid)
                tpw_pkg::REG_INTERRUPT_CONTROL: next_st.interrupt_control = pwdata[7:0];
                tpw_pkg::REG_PIRF: next_st.peripheral_irq_flags = pwdata[7:0] & tpw_pkg::MASK_IRQ_REGS;
                tpw_pkg::REG_TCOUNT: next_st.timer_count = pwdata[7:0];
                tpw_pkg::REG_TCTRL: next_st.timer_control = pwdata[7:0] & tpw_pkg::MASK_TIMER_CONTROL;
                tpw_pkg::REG_DUTY_HI: next_st.duty_upper_byte = pwdata[7:0];
                tpw_pkg::REG_SHADOW: begin
                    if (!pwm) begin
                        next_st.duty_shadow_byte = pwdata[7:0];
                    end
                end
                tpw_pkg::REG_MCTRL: begin
                    next_st.module_control = pwdata[7:0] & tpw_pkg::MASK_MODULE_CONTROL;
                    // separate from the port data latch
                    if ((pwdata[7:0] & tpw_pkg::MASK_MODULE_CONTROL) == tpw_pkg::RST_ZERO) begin
                        next_st.out_latch = 1'b0;
                    end
                end
                tpw_pkg::REG_DIR: next_st.port_b_direction = pwdata[7:0];
                tpw_pkg::REG_PIEN: next_st.peripheral_irq_enables = pwdata[7:0] & tpw_pkg::MASK_IRQ_REGS;
                tpw_pkg::REG_PERIOD: next_st.period_compare = pwdata[7:0];
                default: next_st.peripheral_irq_flags = next_st.peripheral_irq_flags;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (flag_set) begin
            next_st.peripheral_irq_flags[tpw_pkg::FLAG_TIMER_MATCH] = 1'b1;
        end

        // pin, one clock behind the latch
        next_st.pin = st.out_latch && pwm;
        next_st.pin_oe = !st.port_b_direction[tpw_pkg::DIR_MODULATOR_PIN];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.port_b_direction <= tpw_pkg::RST_PORT_B_DIRECTION;
            st.period_compare <= tpw_pkg::RST_PERIOD_COMPARE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign modulator_output_pin = st.pin;
    assign modulator_output_enable = st.pin_oe;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic wr_tc;
    logic wr_mc;
    logic wr_sh;
    assign wr_tc = wr && (rid == tpw_pkg::REG_TCOUNT);
    assign wr_mc = wr && (rid == tpw_pkg::REG_MCTRL);
    assign wr_sh = wr && (rid == tpw_pkg::REG_SHADOW);

    AST_ROLLOVER_CLEARS: assert property (rollover && !wr_tc |=> st.timer_count == 8'h00)
        else $error("count not cleared at period match");
    AST_DUTY_COPIED: assert property (rollover && pwm |=>
        st.duty_shadow_byte == $past(st.duty_upper_byte) && st.duty_low_latch == $past(duty_prog[1:0]))
        else $error("duty not copied at rollover");
    AST_PIN_SET: assert property (rollover && pwm && duty_prog != 10'h000 && !wr_mc |=> st.out_latch ##1 st.pin)
        else $error("pin not set at rollover");
    AST_ZERO_DUTY: assert property (rollover && pwm && duty_prog == 10'h000 |=> !st.out_latch)
        else $error("zero duty set the pin");
    AST_CLEAR_AT_MATCH: assert property (pwm && !rollover && duty_match |=> !st.out_latch ##1 !st.pin)
        else $error("pin not cleared at duty match");
    AST_WIDE_DUTY: assert property (pwm && st.out_latch && duty_buf > {st.period_compare, 2'b11}
        && !rollover && !wr_mc |=> st.out_latch)
        else $error("over-long duty cleared the pin");
    AST_NO_EARLY_APPLY: assert property (!rollover && !wr_sh |=> $stable(st.duty_shadow_byte))
        else $error("shadow changed outside rollover");
    AST_SHADOW_RO: assert property (wr_sh && pwm && !rollover |=> $stable(st.duty_shadow_byte))
        else $error("shadow written in modulator mode");
    AST_MC_ZERO: assert property (wr_mc && pwdata[5:0] == 6'h00 |=> !st.out_latch ##1 !st.pin)
        else $error("zero control did not force latch low");
    AST_DIV1_TICK: assert property (tick && st.timer_control[2:0] == 3'b100 ##1
        (st.timer_control[2:0] == 3'b100 && !clr_pre)[*4] |-> tick)
        else $error("divide by one tick spacing wrong");
    AST_MODE_DECODE: assert property (st.module_control[3:2] == 2'b11 && st.out_latch |=> st.pin)
        else $error("modulator mode not decoded");

    COV_ROLLOVER_HIGH: cover property (rollover && pwm && duty_prog != 10'h000);
    COV_DUTY_MATCH: cover property (pwm && duty_match && st.out_latch);
    COV_DIV16: cover property (tick && st.timer_control[1] && run);

endmodule : tpw_unit
